// ==== hw/adc_fmt_map.svh ====
// Constants for the serial output formatter: widths, latencies, mode codes
`ifndef ADC_FMT_MAP_SVH
`define ADC_FMT_MAP_SVH

`define NUM_LANES 8
`define SAMPLE_W 14
`define WORD_W 16
`define PIPE_DEPTH 11
`define LAT_DEFAULT 11
`define LAT_LOW 8
`define RES_SEL_12 2'h3
`define RES_SEL_14 2'h0
`define RES_SEL_16 2'h1
`define RES_AUX_12 3'h2
`define RES_AUX_NONE 3'h0
`define BITS_12 5'hc
`define BITS_14 5'he
`define BITS_16 5'h10
`define RESET_BIT_IDX 5'hd

`endif

// ==== hw/adc_fmt_pkg.sv ====
// Types shared by the serial output formatter
`include "adc_fmt_map.svh"
package adc_fmt_pkg;
    typedef enum logic [1:0] {MODE_12, MODE_14, MODE_16} res_mode_t;
    typedef logic [`SAMPLE_W-1:0] sample_t;
    typedef sample_t [`NUM_LANES-1:0] sample_bus_t;
    typedef logic [`WORD_W-1:0] word_t;
endpackage

// ==== hw/lane_ctl_if.sv ====
// Load and shift control from the frame sequencer to one lane serializer
`timescale 1ns/10ps
`default_nettype none
interface lane_ctl_if;
    logic load;
    logic shift;
    adc_fmt_pkg::word_t word;
    modport ctl (output load, output shift, output word);
    modport lane (input load, input shift, input word);
endinterface
`default_nettype wire

// ==== hw/lane_serializer.sv ====
// One output lane: loads a 16-bit word and shifts it out MSB first
`timescale 1ns/10ps
`default_nettype none
`include "adc_fmt_map.svh"
module lane_serializer (
    input wire logic clk,
    input wire logic sys_rst,
    lane_ctl_if.lane ctl,
    output var logic bit_out
);
    import adc_fmt_pkg::*;

    word_t sh_r;
    word_t sh_nxt;

    always_comb begin
        sh_nxt = sh_r;
        if (ctl.load) begin
            sh_nxt = ctl.word;
        end else if (ctl.shift) begin
            sh_nxt = {sh_r[`WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_r <= 16'h0000;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    assign bit_out = sh_r[`WORD_W-1];
endmodule
`default_nettype wire

// ==== hw/adc_serial_output_formatter.sv ====
// Serial output formatter: sample latency pipe, resolution modes, bit and frame clocks
//
// Contract
// [RQ1] Each sample reaches the lanes 11 sample periods after capture, or 8 with low latency set.
// [RQ2] Results are 14 bits inside; 12-bit output drops the two lowest bits.
// [RQ3] 16-bit output sends the 14-bit result followed by two zero bits.
// [RQ4] Select 11/010 gives 12 bits at 6 bit clocks, 00/000 14 at 7, 01/000 16 at 8; the code sends one bit per bit clock, so 12, 14 and 16.
// [RQ5] The frame clock lane is timed exactly like the data lanes against the bit clock.
// [RQ6] The receiver marks words by the frame clock rising edge and takes the configured bit count.
`timescale 1ns/10ps
`default_nettype none
`include "adc_fmt_map.svh"
module adc_serial_output_formatter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire adc_fmt_pkg::sample_bus_t sample_data,
    input wire logic low_latency_pin,
    input wire logic [1:0] res_sel_pin,
    input wire logic [2:0] res_aux_pin,
    output logic serial_bit_clock,
    output logic word_frame_clock,
    output logic [`NUM_LANES-1:0] data_lane,
    output logic sample_strobe
);
    import adc_fmt_pkg::*;

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [5:0] cfg_meta_r;
    logic [5:0] cfg_sync_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_meta_r <= 6'h00;
            cfg_sync_r <= 6'h00;
        end else begin
            cfg_meta_r <= {low_latency_pin, res_sel_pin, res_aux_pin};
            cfg_sync_r <= cfg_meta_r;
        end
    end

    // Unlisted select codes fall back to 14 bits rather than stall the link
    function automatic res_mode_t decode_mode(input logic [1:0] sel, input logic [2:0] aux);
        res_mode_t m;
        m = MODE_14;
        if (sel == `RES_SEL_12 && aux == `RES_AUX_12) begin
            m = MODE_12;
        end else if (sel == `RES_SEL_16 && aux == `RES_AUX_NONE) begin
            m = MODE_16;
        end
        return m;
    endfunction

    function automatic logic [4:0] bits_of(input res_mode_t m);
        logic [4:0] n;
        unique case (m)
            MODE_12: n = `BITS_12;
            MODE_14: n = `BITS_14;
            MODE_16: n = `BITS_16;
            default: n = `BITS_14;
        endcase
        return n;
    endfunction

    // ********************************
    // Frame sequencer
    // ********************************
    logic ph_r;
    logic ph_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    res_mode_t mode_r;
    res_mode_t mode_nxt;
    logic lowlat_r;
    logic lowlat_nxt;
    logic word_frame_clock_r;
    logic word_frame_clock_nxt;
    logic strobe_r;
    logic load;
    logic shift;
    logic [4:0] nbits_r;
    sample_bus_t pipe_r [`PIPE_DEPTH];
    sample_bus_t pipe_nxt [`PIPE_DEPTH];
    sample_bus_t tap;

    assign nbits_r = bits_of(mode_r);

    // Bit clock is clk/2; lanes change as it falls, so the receiver samples mid-bit on its rise
    always_comb begin
        ph_nxt = ~ph_r;
        cnt_nxt = cnt_r;
        mode_nxt = mode_r;
        lowlat_nxt = lowlat_r;
        load = 1'b0;
        shift = 1'b0;
        pipe_nxt = pipe_r;
        if (ph_r) begin
            if (cnt_r == nbits_r - 5'h1) begin
                cnt_nxt = 5'h00;
                load = 1'b1;
                // Mode and latency only change on a word boundary
                mode_nxt = decode_mode(cfg_sync_r[4:3], cfg_sync_r[2:0]); // RQ4
                lowlat_nxt = cfg_sync_r[5]; // RQ1
                pipe_nxt[0] = sample_data;
                for (int i = 1; i < `PIPE_DEPTH; i++) begin
                    pipe_nxt[i] = pipe_r[i-1];
                end
            end else begin
                cnt_nxt = cnt_r + 5'h1;
                shift = 1'b1;
            end
        end
        // Half a frame high, counted in half bits so odd word lengths stay at 50 %
        word_frame_clock_nxt = ({cnt_nxt, ph_nxt} < {1'b0, bits_of(mode_nxt)}); // RQ5
    end

    // Tap taken from the pipe before this capture shifts it in
    assign tap = lowlat_nxt ? pipe_r[`LAT_LOW-1] : pipe_r[`LAT_DEFAULT-1]; // RQ1

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_r <= 1'b0;
            cnt_r <= `RESET_BIT_IDX;
            mode_r <= MODE_14;
            lowlat_r <= 1'b0;
            word_frame_clock_r <= 1'b0;
            strobe_r <= 1'b0;
            for (int i = 0; i < `PIPE_DEPTH; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            ph_r <= ph_nxt;
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
            lowlat_r <= lowlat_nxt;
            word_frame_clock_r <= word_frame_clock_nxt;
            strobe_r <= load;
            pipe_r <= pipe_nxt;
        end
    end

    // ********************************
    // Lanes
    // ********************************
    logic [`NUM_LANES-1:0] lane_bit;

    for (genvar g = 0; g < `NUM_LANES; g++) begin : g_lane
        lane_ctl_if ctl ();
        assign ctl.load = load;
        assign ctl.shift = shift;
        // Left aligned: 12-bit frames stop before the two low bits, 16-bit send the zeros
        assign ctl.word = {tap[g], 2'b00}; // RQ2 RQ3
        lane_serializer u_lane (
            .clk(clk),
            .sys_rst(sys_rst),
            .ctl(ctl),
            .bit_out(lane_bit[g])
        );
    end

    assign serial_bit_clock = ph_r;
    assign word_frame_clock = word_frame_clock_r;
    assign data_lane = lane_bit;
    assign sample_strobe = strobe_r;

    // ********************************
    // Checks
    // ********************************
    logic [5:0] frm_len_r;
    logic [4:0] prev_bits_r;
    logic seen_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frm_len_r <= 6'h00;
            prev_bits_r <= 5'h00;
            seen_r <= 1'b0;
        end else if (strobe_r) begin
            frm_len_r <= 6'h01;
            prev_bits_r <= nbits_r;
            seen_r <= 1'b1;
        end else begin
            frm_len_r <= frm_len_r + 6'h01;
        end
    end

    sequence word_start;
        strobe_r && !serial_bit_clock;
    endsequence

    property frame_high_span;
        @(posedge clk) disable iff (sys_rst)
        word_start |-> word_frame_clock [*6];
    endproperty

    a_frame_length: assert property (@(posedge clk) disable iff (sys_rst) // RQ2 RQ4
        strobe_r && seen_r |-> frm_len_r == {prev_bits_r, 1'b0})
        else $error("frame length differs from twice the word length");

    a_frame_edge_aligned: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        $rose(word_frame_clock) |-> word_start)
        else $error("frame clock rose away from a word start");

    a_frame_high_span: assert property (frame_high_span) // RQ5
        else $error("frame clock fell too early");

    a_bit_clock_toggle: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
        !$past(sys_rst) |-> serial_bit_clock != $past(serial_bit_clock))
        else $error("bit clock failed to toggle");

    a_sixteen_pad_zero: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
        mode_r == MODE_16 && cnt_r >= 5'he |-> data_lane == 8'h00)
        else $error("pad bits of a 16-bit word are not zero");

    a_latency_default: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
        strobe_r && !lowlat_r |-> data_lane[0] == $past(pipe_r[`LAT_DEFAULT-1][0][`SAMPLE_W-1]))
        else $error("default latency tap not on lane");

    a_latency_low: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
        strobe_r && lowlat_r |-> data_lane[0] == $past(pipe_r[`LAT_LOW-1][0][`SAMPLE_W-1]))
        else $error("low latency tap not on lane");

    a_mode_twelve: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
        strobe_r && $past(cfg_sync_r[4:0]) == 5'h1a |-> mode_r == MODE_12 && nbits_r == 5'hc)
        else $error("12-bit select not decoded");
endmodule
`default_nettype wire

// ==== test/lane_receiver.sv ====
// Receiving logic model: rebuilds words from the bit clock, frame clock and lanes
`timescale 1ns/10ps
`default_nettype none
module lane_receiver (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic serial_bit_clock,
    input wire logic word_frame_clock,
    input wire logic [7:0] data_lane,
    output logic word_valid,
    output logic [7:0][15:0] rx_words,
    output logic [4:0] rx_count
);
    logic bclk_r;
    logic word_frame_clock_r;
    logic started_r;
    logic [4:0] cnt_r;
    logic [7:0][15:0] acc_r;
    // Bit clock is only sampled, so bits are taken one clk after its rise
    always @(posedge clk or posedge sys_rst) begin
        word_valid <= 1'b0;
        if (sys_rst) begin
            bclk_r <= 1'b0;
            word_frame_clock_r <= 1'b0;
            started_r <= 1'b0;
            cnt_r <= 5'h0;
        end else begin
            bclk_r <= serial_bit_clock;
            if (serial_bit_clock && !bclk_r) begin
                word_frame_clock_r <= word_frame_clock;
                if (word_frame_clock && !word_frame_clock_r) begin
                    word_valid <= started_r;
                    rx_words <= acc_r;
                    rx_count <= cnt_r;
                    started_r <= 1'b1;
                    cnt_r <= 5'h1;
                    for (int g = 0; g < 8; g++) acc_r[g] <= {15'h0, data_lane[g]};
                end else begin
                    cnt_r <= cnt_r + 5'h1;
                    for (int g = 0; g < 8; g++) acc_r[g] <= {acc_r[g][14:0], data_lane[g]};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_adc_serial_output_formatter.sv ====
// Testbench for the serial output formatter with a receiving logic model
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_output_formatter;
    import adc_fmt_pkg::*;
    logic clk, sys_rst, low_latency_pin, serial_bit_clock, word_frame_clock, sample_strobe;
    logic [1:0] res_sel_pin;
    logic [2:0] res_aux_pin;
    logic [7:0] data_lane;
    sample_bus_t sample_data, snap;
    logic word_valid, bclk_d, word_frame_clock_d;
    logic [7:0][15:0] rx_words;
    logic [4:0] rx_count;
    logic [31:0] lfsr_r = 32'hcaaa9de8;
    logic [7:0][15:0] exp_q[$];
    logic [7:0][15:0] e, ex;
    int n_mismatch = 0, checks = 0, cycles = 0, nb = 14, nskip = 0;
    adc_serial_output_formatter adc_serial_output_formatter_i (.clk(clk), .sys_rst(sys_rst),
        .sample_data(sample_data), .low_latency_pin(low_latency_pin),
        .res_sel_pin(res_sel_pin), .res_aux_pin(res_aux_pin),
        .serial_bit_clock(serial_bit_clock), .word_frame_clock(word_frame_clock),
        .data_lane(data_lane), .sample_strobe(sample_strobe));
    lane_receiver lane_receiver_i (.clk(clk), .sys_rst(sys_rst),
        .serial_bit_clock(serial_bit_clock), .word_frame_clock(word_frame_clock),
        .data_lane(data_lane), .word_valid(word_valid), .rx_words(rx_words),
        .rx_count(rx_count));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ****************
    // Stimulus and capture
    // ****************
    always @(negedge clk) begin
        for (int g = 0; g < 8; g++) begin
            lfsr_r = lfsr(lfsr_r);
            sample_data[g] <= lfsr_r[13:0];
        end
    end
    always @(posedge clk) begin
        snap = sample_data;
        #1;
        if (sample_strobe === 1'b1) begin
            for (int g = 0; g < 8; g++) begin
                if (nb == 12) e[g] = {4'h0, snap[g][13:2]};
                else if (nb == 14) e[g] = {2'h0, snap[g]};
                else e[g] = {snap[g], 2'h0};
            end
            exp_q.push_back(e);
        end
    end
    // ****************
    // Output watch
    // ****************
    always @(posedge clk) begin
        bclk_d <= serial_bit_clock;
        word_frame_clock_d <= word_frame_clock;
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            end_sim();
        end
        if (sys_rst === 1'b0 && serial_bit_clock === 1'b1 && cycles > 12) begin
            check("frame_vs_bit", {15'h0, word_frame_clock}, {15'h0, word_frame_clock_d});
            check("bit_toggle", {15'h0, bclk_d}, 16'h0);
        end
        if (word_valid === 1'b1) begin
            if (exp_q.size() == 0) check("queue", 16'h0, 16'h1);
            else ex = exp_q.pop_front();
            if (nskip > 0) nskip--;
            else begin
                check("bits", {11'h0, rx_count}, nb[15:0]);
                for (int g = 0; g < 8; g++) check("lane", rx_words[g], ex[g]);
            end
        end
    end
    // ****************
    // Mode sequence
    // ****************
    initial begin
        logic [1:0] sel_t[5] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h3};
        logic [2:0] aux_t[5] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h2};
        int nb_t[5] = '{12, 14, 16, 14, 12};
        sys_rst = 1'b1;
        low_latency_pin = 1'b0;
        res_sel_pin = 2'h0;
        res_aux_pin = 3'h0;
        repeat (8) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            // Sync stages clear in reset, so the first word still runs in 14-bit mode
            sys_rst <= 1'b1;
            res_sel_pin <= sel_t[i];
            res_aux_pin <= aux_t[i];
            low_latency_pin <= i[0];
            repeat (4) @(negedge clk);
            nb = nb_t[i];
            exp_q.delete();
            repeat (i[0] ? 8 : 11) exp_q.push_back('0);
            nskip = 3;
            sys_rst <= 1'b0;
            repeat (60 * nb) @(negedge clk);
            $display("Mode test %0d done", i);
        end
        end_sim();
    end
endmodule
`default_nettype wire
